// ===== mfg_gen.sv
// Transmit multiframe generator: normal, alarm and idle payload,
// plus the text field octet source for identification messages.
// Assumes payload and control inputs are synchronous to clk.
`default_nettype none

module mfg_gen #(
  parameter int LABEL_N = mfg_pkg::LABEL_OCTETS,
  parameter int LEN_W = $clog2(LABEL_N + 1),
  parameter int IDX_W = $clog2(LABEL_N)
) (
  input wire logic clk,
  input wire logic reset,
  input wire mfg_pkg::mfg_mode_t mode_req,
  output mfg_pkg::mfg_mode_t mode_active,
  input wire logic payload_bit,
  input wire logic payload_valid,
  output logic payload_ready,
  input wire logic x_bit_normal,
  input wire logic [mfg_pkg::CBITS_TOTAL-1:0] c_bits_normal,
  input wire logic [mfg_pkg::CBITS_TOTAL-1:0] c_bits_idle,
  output logic ser_bit,
  output logic ser_mframe_start,
  output logic ser_valid,
  input wire logic ser_ready,
  input wire logic label_is_test,
  input wire logic [8*LABEL_N-1:0] path_facility_label_field,
  input wire logic [LEN_W-1:0] label_len,
  input wire logic [IDX_W-1:0] label_idx,
  output logic [7:0] label_type,
  output logic [7:0] label_octet
);
  import mfg_pkg::*;

  // Elaboration checks: the counters and decode assume the fixed shape
  if (LABEL_N < 2) begin : g_bad_label
    $error("mfg_gen: LABEL_N must be at least 2");
  end
  if (LEN_W < $clog2(LABEL_N + 1) || IDX_W < $clog2(LABEL_N) ||
      IDX_W > LEN_W) begin : g_bad_width
    $error("mfg_gen: LEN_W or IDX_W does not suit LABEL_N");
  end
  if (BLOCK_BITS > 128 || BLOCKS != 8 || SUBFRAMES != 7) begin : g_bad_geom
    $error("mfg_gen: counters assume 8 blocks and 7 subframes");
  end

  // ==========================================================
  // Position counters
  logic [6:0] bit_r;
  logic [2:0] blk_r;
  logic [2:0] sf_r;
  mfg_mode_t mode_r;
  logic par_acc_r;
  logic par_prev_r;

  localparam logic [6:0] LAST_BIT = 7'(BLOCK_BITS - 1);
  localparam logic [2:0] LAST_BLK = 3'(BLOCKS - 1);
  localparam logic [2:0] LAST_SF = 3'(SUBFRAMES - 1);

  wire is_oh = (bit_r == 7'h00);
  wire last_bit = (bit_r == LAST_BIT);
  wire last_blk = (blk_r == LAST_BLK);
  wire last_sf = (sf_r == LAST_SF);
  wire mf_end = last_bit && last_blk && last_sf;
  wire mf_start = is_oh && (blk_r == 3'h0) && (sf_r == 3'h0);

  // ==========================================================
  // Overhead bits
  wire is_xpm = (blk_r == 3'h0);
  wire is_cbit = ~blk_r[0] && !is_xpm;
  wire is_fbit = blk_r[0];
  wire [1:0] c_num = 2'(blk_r[2:1] - 2'h1);
  wire [4:0] c_idx = 5'({sf_r, 1'b0}) + 5'(sf_r) + 5'(c_num);
  wire f_val = (blk_r == 3'h1) ? F1_VAL :
               (blk_r == 3'h3) ? F2_VAL :
               (blk_r == 3'h5) ? F3_VAL : F4_VAL;
  wire m_val = (sf_r == 3'h4) ? M1_VAL :
               (sf_r == 3'h5) ? M2_VAL : M3_VAL;
  wire is_xsf = (sf_r == 3'h0) || (sf_r == 3'h1);
  wire is_psf = (sf_r == 3'h2) || (sf_r == 3'h3);
  wire pattern_on = (mode_r != MODE_NORMAL);

  // [R5] X-bits one
  wire x_val = pattern_on ? PATTERN_X_VAL : x_bit_normal;
  // [R2] [R6] Alignment and parity kept
  wire xpm_val = is_xsf ? x_val : is_psf ? par_prev_r : m_val;
  // [R4] Alarm C zero
  // [R8] [R9] Idle C selection
  wire c_val = (mode_r == MODE_AIS) ? AIS_C_VAL :
               (mode_r == MODE_IDLE) ?
                 ((sf_r == IDLE_ZERO_SF) ? 1'h0 : c_bits_idle[c_idx]) :
               c_bits_normal[c_idx];
  wire oh_val = is_xpm ? xpm_val : is_cbit ? c_val : f_val;

  // ==========================================================
  // Payload bits
  // Phase restarts in each block since every block opens with overhead
  wire [6:0] ph = 7'(bit_r - 7'h01);
  // [R3] Alarm 1010 sequence
  wire ais_val = ~ph[0];
  // [R7] Idle 1100 sequence
  wire idle_val = ~ph[1];
  // [R1] Patterns ignore C-bit use
  wire pl_val = (mode_r == MODE_AIS) ? ais_val :
                (mode_r == MODE_IDLE) ? idle_val : payload_bit;
  wire out_bit = is_oh ? oh_val : pl_val;

  // ==========================================================
  // Stream into the buffer
  logic buf_ready;
  wire need_pl = !is_oh && !pattern_on;
  wire push = buf_ready && (!need_pl || payload_valid);
  assign payload_ready = buf_ready && need_pl;
  assign mode_active = mode_r;

  mfg_buf2 #(
    .WIDTH(2)
  ) u_buf (
    .clk(clk),
    .reset(reset),
    .in_data({mf_start, out_bit}),
    .in_valid(!need_pl || payload_valid),
    .in_ready(buf_ready),
    .out_data({ser_mframe_start, ser_bit}),
    .out_valid(ser_valid),
    .out_ready(ser_ready)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      bit_r <= 7'h00;
      blk_r <= 3'h0;
      sf_r <= 3'h0;
    end else if (push) begin
      bit_r <= last_bit ? 7'h00 : 7'(bit_r + 7'h01);
      if (last_bit) blk_r <= last_blk ? 3'h0 : 3'(blk_r + 3'h1);
      if (last_bit && last_blk) sf_r <= last_sf ? 3'h0 : 3'(sf_r + 3'h1);
    end
  end

  // [R14] Boundary mode switch
  always_ff @(posedge clk) begin
    if (reset) mode_r <= MODE_NORMAL;
    else if (push && mf_end) mode_r <= mode_req;
  end

  // [R2] [R6] Parity over payload
  always_ff @(posedge clk) begin
    if (reset) begin
      par_acc_r <= PARITY_RESET;
      par_prev_r <= PARITY_RESET;
    end else if (push && !is_oh) begin
      par_acc_r <= mf_end ? PARITY_RESET : (par_acc_r ^ out_bit);
      if (mf_end) par_prev_r <= par_acc_r ^ out_bit;
    end
  end

  // ==========================================================
  // Identification text field
  logic [7:0] oct [LABEL_N];
  genvar gi;
  generate
    for (gi = 0; gi < LABEL_N; gi++) begin : g_oct
      assign oct[gi] = path_facility_label_field[8*gi +: 8];
    end
  endgenerate

  wire idx_ok = (LEN_W'(label_idx) < label_len) &&
                (32'(label_idx) < LABEL_N);
  // [R10] [R11] Null past text
  wire [7:0] oct_sel = idx_ok ? oct[label_idx] : ASCII_NULL;

  always_ff @(posedge clk) begin
    if (reset) begin
      label_octet <= ASCII_NULL;
      label_type <= TYPE_IDLE_ID;
    end else begin
      label_octet <= oct_sel;
      // [R12] [R13] Port or generator
      label_type <= label_is_test ? TYPE_TEST_ID : TYPE_IDLE_ID;
    end
  end
endmodule

`default_nettype wire

// ===== mfg_pkg.sv
// Constants and types shared by the multiframe pattern generator.
// Assumes a bit-serial transmit path clocked once per line bit.
//
// Summary of operation
// [R1] Patterns identical whatever the C-bit application
// [R2] Alarm keeps alignment bits and parity
// [R3] Alarm payload 1010, restart after overhead
// [R4] Alarm drives every C-bit to zero
// [R5] Both patterns drive X-bits to one
// [R6] Idle keeps alignment bits and parity
// [R7] Idle payload 1100, restart after overhead
// [R8] Idle zeroes C-bits of subframe three
// [R9] Idle other C-bits settable, may vary
// [R10] Short text field ends with null
// [R11] Absent element starts with null octet
// [R12] Idle message carries 38-octet port field
// [R13] Test message carries 38-octet generator field
// [R14] Mode changes only at multiframe boundary
`default_nettype none

package mfg_pkg;
  // ==========================================================
  // Frame geometry
  localparam int BLOCK_BITS = 85;
  localparam int BLOCKS = 8;
  localparam int SUBFRAMES = 7;
  localparam int CBITS_PER_SF = 3;
  localparam int CBITS_TOTAL = SUBFRAMES * CBITS_PER_SF;
  localparam logic [2:0] IDLE_ZERO_SF = 3'h2;
  // ==========================================================
  // Overhead bit values
  localparam logic F1_VAL = 1'h1;
  localparam logic F2_VAL = 1'h0;
  localparam logic F3_VAL = 1'h0;
  localparam logic F4_VAL = 1'h1;
  localparam logic M1_VAL = 1'h0;
  localparam logic M2_VAL = 1'h1;
  localparam logic M3_VAL = 1'h0;
  localparam logic PATTERN_X_VAL = 1'h1;
  localparam logic AIS_C_VAL = 1'h0;
  // ==========================================================
  // Data-link message fields
  localparam int LABEL_OCTETS = 38;
  localparam logic [7:0] TYPE_IDLE_ID = 8'h34;
  localparam logic [7:0] TYPE_TEST_ID = 8'h32;
  localparam logic [7:0] ASCII_NULL = 8'h00;
  // ==========================================================
  // Reset values
  localparam logic PARITY_RESET = 1'h0;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_AIS,
    MODE_IDLE
  } mfg_mode_t;
endpackage

`default_nettype wire

// ===== mfg_buf2.sv
// Two-entry valid/ready buffer.
// Assumes both sides share clk; accepts a push while full if popping.
`default_nettype none

module mfg_buf2 #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import mfg_pkg::*;

  if (WIDTH < 1) begin : g_bad_width
    $error("mfg_buf2: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] mem_r [2];
  logic rd_r;
  logic wr_r;
  logic [1:0] cnt_r;

  wire do_push = in_valid && in_ready;
  wire do_pop = out_valid && out_ready;

  // Full only at two, so a stalled receiver holds both words
  assign in_ready = (cnt_r != 2'h2) || out_ready;
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rd_r];

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_r <= 1'h0;
      wr_r <= 1'h0;
      cnt_r <= 2'h0;
    end else begin
      if (do_push) wr_r <= ~wr_r;
      if (do_pop) rd_r <= ~rd_r;
      if (do_push && !do_pop) cnt_r <= cnt_r + 2'h1;
      else if (do_pop && !do_push) cnt_r <= cnt_r - 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) mem_r[wr_r] <= in_data;
  end
endmodule

`default_nettype wire

// ===== mfg_line_sink.sv
// Line-side sink model: takes serial bits, can stall one cycle in three.
// Assumes the generator holds ser_* until ready is sampled high.
`default_nettype none
module mfg_line_sink (
  input wire logic clk,
  input wire logic slow,
  output logic ser_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  // ======================================
  // Ready pattern
  logic [1:0] ph = 2'h0;
  // Plain always: ph starts from its declared value, there is no reset pin
  always @(posedge clk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    ser_ready <= !(slow && ph == 2'h0);
  end
endmodule
`default_nettype wire

// ===== mfg_gen_checker.sv
// Checker for the generator's serial stream and label type.
// Assumes bound to mfg_gen; position is counted from taken bits.
`default_nettype none
module mfg_gen_checker
  import mfg_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire mfg_pkg::mfg_mode_t mode_active,
  input wire logic ser_bit,
  input wire logic ser_mframe_start,
  input wire logic ser_valid,
  input wire logic ser_ready,
  input wire logic label_is_test,
  input wire logic [7:0] label_type
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ======================================
  // Bit position; edge subframes skipped as mode leads the buffer
  logic [12:0] pos_r;
  logic seen_r;
  wire tk = ser_valid && ser_ready;
  wire [12:0] ix = ser_mframe_start ? 13'h0 : pos_r;
  wire [2:0] sf = 3'(ix / 13'h2A8);
  wire [2:0] bk = 3'(ix % 13'h2A8 / 13'h55);
  wire [6:0] k = 7'(ix % 13'h55);
  wire mid = sf != 3'h0 && sf != 3'h6;
  wire oh = seen_r && tk && k == 7'h0;
  wire pl = seen_r && tk && k != 7'h0 && mid;
  always_ff @(posedge clk) begin
    if (reset) begin
      pos_r <= 13'h0;
      seen_r <= 1'b0;
    end else if (tk) begin
      pos_r <= ix + 13'h1;
      seen_r <= seen_r || ser_mframe_start;
    end
  end
  // ======================================
  // Properties
  sequence s_stall; ser_valid && !ser_ready; endsequence
  property p_hold; s_stall |=> ser_valid && $stable(ser_bit); endproperty
  a_hold: assert property (p_hold) else $error("bit moved in stall");
  property p_hold_s;
    s_stall |=> ser_valid && $stable(ser_mframe_start);
  endproperty
  a_hold_s: assert property (p_hold_s) else $error("start moved in stall");
  property p_len;
    seen_r && tk |-> ser_mframe_start == (pos_r == 13'h1298);
  endproperty
  a_len: assert property (p_len) else $error("frame length");
  property p_f; oh && bk[0] |-> ser_bit == (bk == 3'h1 || bk == 3'h7);
  endproperty
  a_f: assert property (p_f) else $error("F bit");
  property p_m; oh && bk == 3'h0 && sf > 3'h3 |-> ser_bit == (sf == 3'h5);
  endproperty
  a_m: assert property (p_m) else $error("M bit");
  property p_x;
    oh && bk == 3'h0 && sf == 3'h1 && mode_active != MODE_NORMAL |-> ser_bit;
  endproperty
  a_x: assert property (p_x) else $error("X bit");
  property p_ais; pl && mode_active == MODE_AIS |-> ser_bit == k[0];
  endproperty
  a_ais: assert property (p_ais) else $error("alarm payload");
  property p_idl;
    pl && mode_active == MODE_IDLE |-> ser_bit == (k[1] ^ k[0]);
  endproperty
  a_idl: assert property (p_idl) else $error("idle payload");
  property p_c; oh && mid && bk != 3'h0 && !bk[0] &&
    (mode_active == MODE_AIS || mode_active == MODE_IDLE && sf == 3'h2)
    |-> !ser_bit;
  endproperty
  a_c: assert property (p_c) else $error("C bit");
  property p_type; !$past(reset) |-> label_type ==
    ($past(label_is_test) ? TYPE_TEST_ID : TYPE_IDLE_ID);
  endproperty
  a_type: assert property (p_type) else $error("label type");
endmodule

bind mfg_gen mfg_gen_checker i_chk (.clk(clk), .reset(reset),
  .mode_active(mode_active), .ser_bit(ser_bit),
  .ser_mframe_start(ser_mframe_start), .ser_valid(ser_valid),
  .ser_ready(ser_ready), .label_is_test(label_is_test),
  .label_type(label_type));
`default_nettype wire

// ===== mfg_gen_tb.sv
// Self-checking bench for the multiframe pattern generator.
// Assumes mfg_gen, its checker and the line sink; one 40 MHz clock.
`default_nettype none
module mfg_gen_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mfg_pkg::*;
  logic clk = 1'b0, reset = 1'b1, x_n = 1'b1, slow = 1'b0;
  mfg_mode_t mode_req = MODE_NORMAL;
  mfg_mode_t m_act;
  logic [4:0] src = 5'h01, rx = 5'h01;
  logic [20:0] c_n = 21'h155555, c_i = 21'h000000;
  logic is_test = 1'b0, b = 1'b0, s = 1'b0, par = 1'b0, acc;
  logic [303:0] field;
  logic [5:0] len = 6'h00, idx = 6'h00;
  logic [7:0] l_oct, l_type;
  logic p_rdy, ser_bit, ser_start, ser_valid, ser_ready;
  int n_errors = 0, comparisons = 0;
  initial forever #12.5 clk = ~clk;
  // Five-bit ring gives frame parity that is not always zero
  always @(posedge clk) if (!reset && p_rdy) src <= {src[3:0], src[4]};
  mfg_gen i_dut (.clk(clk), .reset(reset), .mode_req(mode_req),
    .mode_active(m_act), .payload_bit(src[0]), .payload_valid(1'b1),
    .payload_ready(p_rdy), .x_bit_normal(x_n), .c_bits_normal(c_n),
    .c_bits_idle(c_i), .ser_bit(ser_bit), .ser_mframe_start(ser_start),
    .ser_valid(ser_valid), .ser_ready(ser_ready), .label_is_test(is_test),
    .path_facility_label_field(field), .label_len(len), .label_idx(idx),
    .label_type(l_type), .label_octet(l_oct));
  mfg_line_sink i_sink (.clk(clk), .slow(slow), .ser_ready(ser_ready));
  // ======================================
  // Shared tasks
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic get_bit();
    for (int n = 0; n < 20; n++) begin
      @(negedge clk);
      if (ser_valid && ser_ready) begin
        b = ser_bit;
        s = ser_start;
        @(posedge clk);
        return;
      end
    end
    n_errors++;
    $display("ERROR %0t no output bit", $time);
    conclude();
  endtask
  // ======================================
  // Scenarios
  task automatic frame(mfg_mode_t m, mfg_mode_t nx);
    int sf, bk, k;
    logic e;
    acc = 1'b0;
    for (int i = 0; i < 4760; i++) begin
      sf = i / 680;
      bk = i % 680 / 85;
      k = i % 85;
      if (i == 0) mode_req <= nx;
      // The generator runs ahead, so this frame's mode m is already in force here; nx waits for the boundary
      if (i == 0) chk(8'(m_act), 8'(m));
      if (k != 0) begin
        e = m == MODE_AIS ? k[0] : m == MODE_IDLE ? k[1] ^ k[0] : rx[0];
        if (m == MODE_NORMAL) rx = {rx[3:0], rx[4]};
        acc ^= b;
      end else if (bk == 0)
        e = sf < 2 ? (m == MODE_NORMAL ? x_n : 1'b1) : sf < 4 ? par : sf == 5;
      else if (bk % 2 == 1)
        e = bk == 1 || bk == 7;
      else if (m == MODE_AIS || m == MODE_IDLE && sf == 2)
        e = 1'b0;
      else
        e = m == MODE_IDLE ? c_i[sf*3+bk/2-1] : c_n[sf*3+bk/2-1];
      chk(8'(s), 8'(i == 0));
      chk(8'(b), 8'(e));
      get_bit();
    end
    par = acc;
    $display("frame test done, mode %0d", m);
  endtask
  task automatic lbl(logic [5:0] l, logic [5:0] x, logic t);
    len <= l;
    idx <= x;
    is_test <= t;
    @(posedge clk);
    @(negedge clk);
    chk(l_oct, x < l ? 8'h41 + 8'(x) : 8'h00);
    chk(l_type, t ? TYPE_TEST_ID : TYPE_IDLE_ID);
    @(posedge clk);
    $display("label test done");
  endtask
  initial begin
    for (int i = 0; i < 38; i++) field[8*i+:8] = 8'h41 + 8'(i);
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    for (int n = 0; n < 8 && !s; n++) get_bit();
    frame(MODE_NORMAL, MODE_AIS);
    slow <= 1'b1;
    c_n <= 21'h0A5A5A;
    x_n <= 1'b0;
    frame(MODE_AIS, MODE_IDLE);
    slow <= 1'b0;
    c_i <= 21'h1FFFFF;
    frame(MODE_IDLE, MODE_IDLE);
    c_i <= 21'h0ABCDE;
    frame(MODE_IDLE, MODE_NORMAL);
    // Stall the line while payload is being drawn from the source
    slow <= 1'b1;
    frame(MODE_NORMAL, MODE_NORMAL);
    lbl(6'h00, 6'h00, 1'b0);
    lbl(6'h05, 6'h04, 1'b1);
    lbl(6'h05, 6'h05, 1'b0);
    lbl(6'h26, 6'h25, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
